// *** verilog/scrc_map.svh ***
`ifndef SCRC_MAP_SVH
`define SCRC_MAP_SVH

// Register byte offsets on the Wishbone slave.
`define SCRC_OFS_CTRL 5'h00
`define SCRC_OFS_CLKDIV 5'h04
`define SCRC_OFS_PWRCTL 5'h08
`define SCRC_OFS_CAUSE 5'h0C
`define SCRC_OFS_STATUS 5'h10
`define SCRC_OFS_SLOWRC 5'h14

// Control register fields.
`define SCRC_CTRL_MODE_LSB 0
`define SCRC_CTRL_GO 3
`define SCRC_CTRL_FDET_EN 4
`define SCRC_CTRL_POR_EN 5
`define SCRC_CTRL_SM_EN 6
`define SCRC_CTRL_POR_MASK 7
`define SCRC_CTRL_OSC_EN 8
`define SCRC_CTRL_OSC_MODE 9
`define SCRC_CTRL_MAIN_SEL 10
`define SCRC_CTRL_RST 11'h030

// Divider, peripheral power control and reset cause.
`define SCRC_DIV_MAX_SHIFT 3'h2
`define SCRC_PWRCTL_PIN 8
`define SCRC_PWRCTL_RST 9'h1FF
`define SCRC_CAUSE_POR 0
`define SCRC_CAUSE_EXT 1
`define SCRC_CAUSE_SLEEP 2
`define SCRC_CAUSE_SPOR 3
`define SCRC_CAUSE_RST 4'h1

// Cycles for which disabling the supply detector counts as a hazard.
`define SCRC_POR_WINDOW 3'h4

`endif

// *** verilog/scrc_pkg.sv ***
package scrc_pkg;
    typedef enum logic [1:0] {
        SCRC_RUN = 2'b00,
        SCRC_SLEEP = 2'b01,
        SCRC_SHUTDOWN = 2'b10
    } scrc_state_t;

    typedef enum logic [2:0] {
        SCRC_ACTIVE = 3'b000,
        SCRC_IDLE = 3'b001,
        SCRC_FROZEN = 3'b010,
        SCRC_STANDBY = 3'b011,
        SCRC_STOP = 3'b100,
        SCRC_STATIC = 3'b101,
        SCRC_OFF = 3'b110
    } scrc_mode_t;
endpackage : scrc_pkg

// *** verilog/scrc_top.sv ***
// How it works
// - Divider above four keeps fast clocks during deep sleep.
// - External reset in shutdown logged as power-on.
// - Hazard cases let supply detector reset despite mask.
// - Detector switch-off while on the main oscillator sets flag, falls back to RC.
// - Autonomous wake in idle/frozen masks other bus clocks.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "scrc_map.svh"

module scrc_top (
    input wire logic sys_clk_i, // 20 MHz system clock.
    input wire logic sys_rst_i, // Asynchronous power-on reset, high.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write.
    input wire logic [4:0] wb_adr_i, // Byte address.
    input wire logic [3:0] wb_sel_i, // Byte lanes.
    input wire logic [31:0] wb_dat_i, // Write data.
    output logic [31:0] wb_dat_o, // Read data.
    output logic wb_ack_o, // Acknowledge.
    input wire logic ext_reset_i, // External reset pin, high.
    input wire logic wake_i, // Wake pin.
    input wire logic clk_fail_i, // Main oscillator failure seen.
    input wire logic debug_attached_i, // Debugger connected.
    input wire logic por_glitch_i, // Supply detector trip.
    input wire logic [7:0] walk_req_i, // Autonomous wake requests.
    output logic hs_clk_en_o, // High-speed sources enabled.
    output logic sysrc_en_o, // System RC oscillator enabled.
    output logic main_clk_sel_o, // 1 main oscillator, 0 system RC.
    output logic [7:0] pb_clk_en_o, // Peripheral bus clock enables.
    output logic sys_reset_o, // Internal reset pulse.
    output logic rc_slow_pin_o // Slow RC clock on its pin.
);
    logic [12:0] sync_a;
    logic [12:0] sync_b;
    logic ext_s, wake_s, fail_s, dbg_s, glitch_s, ext_d;
    logic [7:0] walk_s;
    logic [10:0] ctrl;
    logic [2:0] pb_shift;
    logic [8:0] pwr_ctl;
    logic [3:0] cause;
    logic fdet_flag, rc_en;
    logic [1:0] rc_stat;
    logic [2:0] por_win;
    scrc_pkg::scrc_state_t state;
    scrc_pkg::scrc_mode_t mode;
    logic wr, hazard, por_fire, sysrc_off, fdet_off, sleep_now;

    // Every pin is two-flop synchronised; only the second stage is read.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sync_a <= 13'h0000;
            sync_b <= 13'h0000;
        end
        else
        begin
            sync_a <= {walk_req_i, por_glitch_i, debug_attached_i, clk_fail_i, wake_i,
                ext_reset_i};
            sync_b <= sync_a;
        end
    end
    assign {walk_s, glitch_s, dbg_s, fail_s, wake_s, ext_s} = sync_b;

    // Edge memory for the external reset so one press logs once.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ext_d <= 1'b0;
        else
            ext_d <= ext_s;
    end

    // Bus decode; all writes use full words, byte lane 0 is required.
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign mode = scrc_pkg::scrc_mode_t'(ctrl[`SCRC_CTRL_MODE_LSB +: 3]);
    assign sleep_now = wr && (wb_adr_i == `SCRC_OFS_CTRL) && wb_dat_i[`SCRC_CTRL_GO];
    assign fdet_off = wr && (wb_adr_i == `SCRC_OFS_CTRL) && ctrl[`SCRC_CTRL_FDET_EN]
        && !wb_dat_i[`SCRC_CTRL_FDET_EN];
    assign sysrc_off = (mode == scrc_pkg::SCRC_STATIC) || (mode == scrc_pkg::SCRC_OFF);

    // The acknowledge is registered, so every access takes one wait cycle.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    // Read data is captured with the acknowledge; unmapped reads give zero.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            wb_dat_o <= 32'h0000_0000;
        else
        begin
            unique case (wb_adr_i)
                `SCRC_OFS_CTRL: wb_dat_o <= {21'h000000, ctrl & 11'h7F7};
                `SCRC_OFS_CLKDIV: wb_dat_o <= {29'h00000000, pb_shift};
                `SCRC_OFS_PWRCTL: wb_dat_o <= {23'h000000, pwr_ctl};
                `SCRC_OFS_CAUSE: wb_dat_o <= {28'h0000000, cause};
                `SCRC_OFS_STATUS: wb_dat_o <= {27'h0000000, rc_stat[1], hs_clk_en_o,
                    state, fdet_flag};
                `SCRC_OFS_SLOWRC: wb_dat_o <= {31'h00000000, rc_stat[1]};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Control register; a detector switch-off forces the RC clock and beats the write.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ctrl <= `SCRC_CTRL_RST;
        else
        begin
            if (wr && (wb_adr_i == `SCRC_OFS_CTRL))
                ctrl <= wb_dat_i[10:0] & 11'h7F7;
            if (fdet_off && ctrl[`SCRC_CTRL_MAIN_SEL])
                ctrl[`SCRC_CTRL_MAIN_SEL] <= 1'b0;
            else if (ctrl[`SCRC_CTRL_FDET_EN] && fail_s)
                ctrl[`SCRC_CTRL_MAIN_SEL] <= 1'b0;
        end
    end

    // Divider, peripheral power control and slow RC enable registers.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pb_shift <= 3'h0;
            pwr_ctl <= `SCRC_PWRCTL_RST;
            rc_en <= 1'b0;
        end
        else if (wr)
        begin
            if (wb_adr_i == `SCRC_OFS_CLKDIV)
                pb_shift <= wb_dat_i[2:0];
            if (wb_adr_i == `SCRC_OFS_PWRCTL)
                pwr_ctl <= wb_dat_i[8:0];
            if (wb_adr_i == `SCRC_OFS_SLOWRC)
                rc_en <= wb_dat_i[0];
        end
    end

    // The slow RC reports its state two cycles late; software polls it.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rc_stat <= 2'b00;
        else
            rc_stat <= {rc_stat[0], rc_en};
    end
    assign rc_slow_pin_o = rc_stat[1] && pwr_ctl[`SCRC_PWRCTL_PIN];

    // Clock-failure flag: write one to clear, a new event wins over the clear.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            fdet_flag <= 1'b0;
        else if ((fdet_off && ctrl[`SCRC_CTRL_MAIN_SEL]) || (ctrl[`SCRC_CTRL_FDET_EN] && fail_s))
            fdet_flag <= 1'b1;
        else if (wr && (wb_adr_i == `SCRC_OFS_STATUS) && wb_dat_i[0])
            fdet_flag <= 1'b0;
    end

    // Window after software disables the supply detector.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            por_win <= 3'h0;
        else if (wr && (wb_adr_i == `SCRC_OFS_CTRL) && ctrl[`SCRC_CTRL_POR_EN]
            && !wb_dat_i[`SCRC_CTRL_POR_EN])
            por_win <= `SCRC_POR_WINDOW;
        else if (por_win != 3'h0)
            por_win <= por_win - 3'h1;
    end

    // In the hazard cases the mask bit is ignored, as the silicon does.
    assign hazard = (por_win != 3'h0) || ctrl[`SCRC_CTRL_SM_EN]
        || ((state == scrc_pkg::SCRC_SHUTDOWN) && dbg_s);
    assign por_fire = glitch_s && (hazard || (ctrl[`SCRC_CTRL_POR_EN]
        && !ctrl[`SCRC_CTRL_POR_MASK]));

    // Sleep sequencer; shutdown is left only through a reset.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state <= scrc_pkg::SCRC_RUN;
        else if (sys_reset_o)
            state <= scrc_pkg::SCRC_RUN;
        else
        begin
            unique case (state)
                scrc_pkg::SCRC_RUN:
                    if (sleep_now && wb_dat_i[2:0] == scrc_pkg::SCRC_OFF)
                        state <= scrc_pkg::SCRC_SHUTDOWN;
                    else if (sleep_now && wb_dat_i[2:0] != scrc_pkg::SCRC_ACTIVE)
                        state <= scrc_pkg::SCRC_SLEEP;
                scrc_pkg::SCRC_SLEEP:
                    if (wake_s)
                        state <= scrc_pkg::SCRC_RUN;
                scrc_pkg::SCRC_SHUTDOWN:
                    state <= scrc_pkg::SCRC_SHUTDOWN;
                default:
                    state <= scrc_pkg::SCRC_RUN;
            endcase
        end
    end

    // Internal reset pulse and its cause; a fresh cause wins over a clear.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sys_reset_o <= 1'b0;
            cause <= `SCRC_CAUSE_RST;
        end
        else
        begin
            sys_reset_o <= 1'b0;
            if (wr && (wb_adr_i == `SCRC_OFS_CAUSE))
                cause <= cause & ~wb_dat_i[3:0];
            if (sys_reset_o)
                sys_reset_o <= 1'b0;
            else if (ext_s && !ext_d)
            begin
                sys_reset_o <= 1'b1;
                if (state == scrc_pkg::SCRC_SHUTDOWN)
                    cause <= 4'h1 << `SCRC_CAUSE_POR;
                else
                    cause <= 4'h1 << `SCRC_CAUSE_EXT;
            end
            else if (por_fire)
            begin
                sys_reset_o <= 1'b1;
                cause <= 4'h1 << `SCRC_CAUSE_SPOR;
            end
            else if ((state == scrc_pkg::SCRC_SHUTDOWN) && wake_s)
            begin
                sys_reset_o <= 1'b1;
                cause <= 4'h1 << `SCRC_CAUSE_SLEEP;
            end
        end
    end

    // Fast sources stay on in deep sleep when the divider exceeds four.
    always_comb
    begin
        sysrc_en_o = !((state != scrc_pkg::SCRC_RUN) && sysrc_off);
        if (state == scrc_pkg::SCRC_RUN)
            hs_clk_en_o = ctrl[`SCRC_CTRL_OSC_EN];
        else if (sysrc_off && (pb_shift > `SCRC_DIV_MAX_SHIFT))
            hs_clk_en_o = ctrl[`SCRC_CTRL_OSC_EN];
        else
            hs_clk_en_o = ctrl[`SCRC_CTRL_OSC_EN] && (mode < scrc_pkg::SCRC_STANDBY);
    end
    assign main_clk_sel_o = ctrl[`SCRC_CTRL_MAIN_SEL];

    // Bus clock gating; software must mask requests before idle or frozen.
    always_comb
    begin
        if (state == scrc_pkg::SCRC_RUN)
            pb_clk_en_o = pwr_ctl[7:0];
        else if ((mode == scrc_pkg::SCRC_IDLE || mode == scrc_pkg::SCRC_FROZEN)
            && (walk_s != 8'h00))
            pb_clk_en_o = walk_s;
        else if (mode == scrc_pkg::SCRC_IDLE)
            pb_clk_en_o = pwr_ctl[7:0];
        else
            pb_clk_en_o = 8'h00;
    end

    property p_hs_kept;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == scrc_pkg::SCRC_SLEEP && sysrc_off && pb_shift > 3'h2
            && ctrl[`SCRC_CTRL_OSC_EN]) |-> hs_clk_en_o && !sysrc_en_o;
    endproperty
    a_hs_kept: assert property (p_hs_kept) else $error("fast clock stopped");

    property p_hs_stop;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == scrc_pkg::SCRC_SLEEP && sysrc_off && pb_shift <= 3'h2) |-> !hs_clk_en_o;
    endproperty
    a_hs_stop: assert property (p_hs_stop) else $error("fast clock kept");

    property p_shut_por;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == scrc_pkg::SCRC_SHUTDOWN && ext_s && !ext_d && !sys_reset_o)
            |=> sys_reset_o && cause == 4'h1 ##1 state == scrc_pkg::SCRC_RUN;
    endproperty
    a_shut_por: assert property (p_shut_por) else $error("shutdown cause wrong");

    property p_hazard_fire;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (glitch_s && hazard && !sys_reset_o && !(ext_s && !ext_d)) |=> sys_reset_o && cause[3];
    endproperty
    a_hazard_fire: assert property (p_hazard_fire) else $error("masked reset lost");

    property p_mask_holds;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (glitch_s && !hazard && ctrl[`SCRC_CTRL_POR_MASK] && !ext_s && !wake_s) |=> !cause[3]
            || $past(cause[3]);
    endproperty
    a_mask_holds: assert property (p_mask_holds) else $error("mask ignored");

    property p_cfd_fall;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (fdet_off && ctrl[`SCRC_CTRL_MAIN_SEL]) |=> fdet_flag && !main_clk_sel_o;
    endproperty
    a_cfd_fall: assert property (p_cfd_fall) else $error("no fallback");

    property p_walk_mask;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == scrc_pkg::SCRC_SLEEP && mode == scrc_pkg::SCRC_FROZEN && walk_s != 8'h00)
            |-> pb_clk_en_o == walk_s;
    endproperty
    a_walk_mask: assert property (p_walk_mask) else $error("bus clocks not masked");

    property p_rc_read;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(rc_en) ##1 rc_en |=> rc_stat[1];
    endproperty
    a_rc_read: assert property (p_rc_read) else $error("slow RC readback late");

    c_shutdown: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state == scrc_pkg::SCRC_SHUTDOWN ##1 sys_reset_o);
    c_walk: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state == scrc_pkg::SCRC_SLEEP && walk_s != 8'h00);
    c_fdet: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) $rose(fdet_flag));
endmodule : scrc_top

// *** testbench/test_sleep_clock_reset_control.sv ***
`timescale 1ns/1ps
`include "scrc_map.svh"

module test_sleep_clock_reset_control;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic ext_reset_i = 1'b0, wake_i = 1'b0, clk_fail_i = 1'b0, debug_attached_i = 1'b0;
    logic por_glitch_i = 1'b0, wb_ack_o, hs_clk_en_o, sysrc_en_o, main_clk_sel_o;
    logic sys_reset_o, rc_slow_pin_o;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [7:0] walk_req_i = 8'h00, pb_clk_en_o, w;
    logic [2:0] m, n;
    int mismatches = 0, checks_done = 0, seed = 54131, i;

    scrc_top i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_reset_i(ext_reset_i), .wake_i(wake_i), .clk_fail_i(clk_fail_i),
        .debug_attached_i(debug_attached_i), .por_glitch_i(por_glitch_i),
        .walk_req_i(walk_req_i), .hs_clk_en_o(hs_clk_en_o), .sysrc_en_o(sysrc_en_o),
        .main_clk_sel_o(main_clk_sel_o), .pb_clk_en_o(pb_clk_en_o),
        .sys_reset_o(sys_reset_o), .rc_slow_pin_o(rc_slow_pin_o));

    // The 20 MHz system clock.
    initial
    begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; ack is read in the active region, so it is the value sampled at the edge.
    task wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            summarize();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wb

    // Waits a bounded time for one reset pulse and checks that it is not repeated.
    task wait_rst;
        int k;
        k = 0;
        while (sys_reset_o !== 1'b1 && k < 10)
        begin
            @(posedge sys_clk_i);
            k++;
        end
        chk({31'h0, sys_reset_o}, 32'h1);
        @(posedge sys_clk_i);
        chk({31'h0, sys_reset_o}, 32'h0);
    endtask : wait_rst

    // The wake pin passes two sync flops, so four edges are ample.
    task wake_up;
        wake_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        wake_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        wb(1'b0, `SCRC_OFS_STATUS, 32'h0);
        chk({30'h0, rd[2:1]}, 32'h0);
    endtask : wake_up

    task poll_rc(input logic v);
        int k;
        k = 0;
        do
        begin
            wb(1'b0, `SCRC_OFS_SLOWRC, 32'h0);
            k++;
        end while (rd[0] !== v && k < 10);
        chk({31'h0, rd[0]}, {31'h0, v});
    endtask : poll_rc

    // Fast sources survive sleep for light modes, or for RC-off modes with a divider above four.
    function automatic logic exp_hs(input logic [2:0] md, input logic [2:0] dv);
        return (md < 3'h3) || ((md == 3'h5 || md == 3'h6) && dv > 3'h2);
    endfunction : exp_hs

    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        wb(1'b0, `SCRC_OFS_CTRL, 32'h0);
        chk(rd, 32'h030);
        wb(1'b0, `SCRC_OFS_PWRCTL, 32'h0);
        chk(rd, 32'h1FF);
        wb(1'b0, `SCRC_OFS_CAUSE, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, 5'h1C, 32'hFFFF_FFFF);
        wb(1'b0, 5'h1C, 32'h0);
        chk(rd, 32'h0);
        chk({24'h0, pb_clk_en_o}, 32'hFF);
        $display("test reset values done");
        // Random divider and mode pairs, with the two boundary dividers forced first.
        for (i = 0; i < 10; i++)
        begin
            n = (i < 2) ? 3'h3 - i[2:0] : 3'($random(seed));
            m = (i < 2) ? 3'h5 : 3'h1 + 3'($unsigned($random(seed)) % 5);
            wb(1'b1, `SCRC_OFS_CLKDIV, {29'h0, n});
            wb(1'b1, `SCRC_OFS_CTRL, {21'h0, 11'h138} | {29'h0, m});
            repeat (2) @(posedge sys_clk_i);
            chk({31'h0, hs_clk_en_o}, {31'h0, exp_hs(m, n)});
            chk({31'h0, sysrc_en_o}, {31'h0, m < 3'h5});
            wake_up();
        end
        $display("test deep sleep clocks done");
        wb(1'b1, `SCRC_OFS_PWRCTL, 32'h0A5);
        wb(1'b1, `SCRC_OFS_CTRL, 32'h339);
        for (i = 0; i < 5; i++)
        begin
            w = (i == 0) ? 8'h00 : 8'($random(seed));
            walk_req_i <= w;
            repeat (4) @(posedge sys_clk_i);
            chk({24'h0, pb_clk_en_o}, (w != 8'h00) ? {24'h0, w} : 32'hA5);
        end
        walk_req_i <= 8'h00;
        wake_up();
        wb(1'b1, `SCRC_OFS_PWRCTL, 32'h100);
        wb(1'b1, `SCRC_OFS_CTRL, 32'h33A);
        chk({24'h0, pb_clk_en_o}, 32'h0);
        walk_req_i <= 8'h10;
        repeat (4) @(posedge sys_clk_i);
        chk({24'h0, pb_clk_en_o}, 32'h10);
        walk_req_i <= 8'h00;
        wake_up();
        $display("test autonomous wake clocks done");
        wb(1'b1, `SCRC_OFS_CTRL, 32'h530);
        chk({31'h0, main_clk_sel_o}, 32'h1);
        wb(1'b1, `SCRC_OFS_CTRL, 32'h520);
        chk({31'h0, main_clk_sel_o}, 32'h0);
        wb(1'b0, `SCRC_OFS_STATUS, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        wb(1'b1, `SCRC_OFS_STATUS, 32'h1);
        wb(1'b0, `SCRC_OFS_STATUS, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        wb(1'b1, `SCRC_OFS_CTRL, 32'h530);
        clk_fail_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        clk_fail_i <= 1'b0;
        chk({31'h0, main_clk_sel_o}, 32'h0);
        wb(1'b1, `SCRC_OFS_STATUS, 32'h1);
        $display("test clock failure fallback done");
        // Shutdown exits only through reset; the cause register tells the paths apart.
        wb(1'b1, `SCRC_OFS_CTRL, 32'h03E);
        ext_reset_i <= 1'b1;
        wait_rst();
        ext_reset_i <= 1'b0;
        wb(1'b0, `SCRC_OFS_CAUSE, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, `SCRC_OFS_CTRL, 32'h03E);
        wake_i <= 1'b1;
        wait_rst();
        wake_i <= 1'b0;
        wb(1'b0, `SCRC_OFS_CAUSE, 32'h0);
        chk(rd, 32'h4);
        ext_reset_i <= 1'b1;
        wait_rst();
        ext_reset_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        wb(1'b0, `SCRC_OFS_CAUSE, 32'h0);
        chk(rd, 32'h2);
        $display("test reset cause done");
        wb(1'b1, `SCRC_OFS_CTRL, 32'h0F0);
        por_glitch_i <= 1'b1;
        wait_rst();
        por_glitch_i <= 1'b0;
        wb(1'b0, `SCRC_OFS_CAUSE, 32'h0);
        chk(rd, 32'h8);
        // Outside the hazard cases the mask holds; disabling the detector opens a window.
        wb(1'b1, `SCRC_OFS_CTRL, 32'h0B0);
        wb(1'b1, `SCRC_OFS_CAUSE, 32'hF);
        por_glitch_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        chk({31'h0, sys_reset_o}, 32'h0);
        wb(1'b0, `SCRC_OFS_CAUSE, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, `SCRC_OFS_CTRL, 32'h090);
        wait_rst();
        por_glitch_i <= 1'b0;
        wb(1'b0, `SCRC_OFS_CAUSE, 32'h0);
        chk(rd, 32'h8);
        wb(1'b1, `SCRC_OFS_CTRL, 32'h030);
        $display("test supply detector hazard done");
        wb(1'b1, `SCRC_OFS_SLOWRC, 32'h1);
        poll_rc(1'b1);
        chk({31'h0, rc_slow_pin_o}, 32'h1);
        wb(1'b1, `SCRC_OFS_PWRCTL, 32'h0FF);
        chk({31'h0, rc_slow_pin_o}, 32'h0);
        wb(1'b1, `SCRC_OFS_SLOWRC, 32'h0);
        poll_rc(1'b0);
        $display("test slow oscillator release done");
        summarize();
    end
endmodule : test_sleep_clock_reset_control
